// *** src/bsa_boot_alloc.sv ***
// Operation
// [R01] after power-up follow the run/stop selector
// [R02] factory-reset state: stop-to-run enters run with no program
// [R03] valid configuration: run executes the battery-backed program
// [R04] lost backed memory forces a full memory reset at start-up
// [R05] after that reset, a present card loads code and data
// [R06] no card: load permanent protected blocks if any exist
// [R07] unbuffered start runs only if selector allows and handler exists
// [R08] unbuffered start logs an automatic full reset event
// [R09] depleted battery sets the fault flag and full reset
// [R10] flag clears only after 30 s powered with charged battery; the code also clears it on every reset
// [R11] digital modules addressed from zero ascending by slot
// [R12] unconfigured analog modules at even addresses from 256
// [R13] peripheral space 0..8191, images 0..255 each
// [R14] both images refresh at each program cycle end
// [R15] at most 8 configured per row, 32 per row overall
// [R16] module data reachable directly or via the images
// [R17] hardware configuration address replaces automatic allocation
// [R18] digital takes 4 bytes, other modules 16 bytes
// [R19] digital start is four times slot minus one
// [R20] other modules start at sixteen times slot minus one plus 256
// [R21] mode selector synchronised, debounced, sampled at reset end and on change
module bsa_boot_alloc
  import bsa_pkg::*;
#(
  parameter longint unsigned BATT_OK_CYCLES = BATT_OK_CYC
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_rstn,
  // operator and power state (pins)
  input  wire logic              i_mode_run,
  input  wire logic              i_backup_valid,
  input  wire logic              i_battery_ok,
  input  wire logic              i_card_present,
  input  wire logic              i_prot_blocks,
  input  wire logic              i_handler_block,
  input  wire logic              i_valid_config,
  // firmware handshakes
  input  wire logic              i_clear_done,
  input  wire logic              i_load_done,
  input  wire logic              i_cycle_done,
  // slot scan
  input  wire logic              i_hw_cfg,
  input  wire logic [4:0]        i_slot,
  input  wire logic [1:0]        i_slot_kind,
  input  wire logic [12:0]       i_slot_cfg_addr,
  // peripheral access
  input  wire logic              i_acc_img,
  input  wire logic [12:0]       i_acc_addr,
  // state outputs
  output logic                   o_run,
  output logic                   o_program_loaded,
  output logic                   o_clear_req,
  output logic [1:0]             o_load_src,
  output logic                   o_load_req,
  output logic                   o_battery_fault_flag,
  output logic                   o_log_auto_reset,
  output logic                   o_image_refresh,
  // allocation outputs
  output logic [12:0]            o_slot_addr,
  output logic [4:0]             o_slot_span,
  output logic                   o_slot_ok,
  output logic                   o_acc_ok
);
  bsa_state_e st_q;
  bsa_state_e st_d;

  // pin synchronisers keep running through reset so the start state sees real pins
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  always_ff @(posedge i_clk) begin
    pin_s1_q <= {i_mode_run, i_backup_valid, i_battery_ok, i_card_present,
                 i_prot_blocks, i_handler_block, i_valid_config};
    pin_s2_q <= pin_s1_q;
  end
  logic mode_s, backup_s, batt_s, card_s, prot_s, hand_s, cfg_s;
  assign {mode_s, backup_s, batt_s, card_s, prot_s, hand_s, cfg_s} = pin_s2_q;

  // mode selector debounce
  logic [15:0] deb_cnt_q;
  logic        mode_q;
  logic        first_q;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      deb_cnt_q <= '0;
      mode_q    <= 1'b0;
    end else if (first_q) begin
      deb_cnt_q <= '0;
      mode_q    <= mode_s; // R21
    end else if (mode_s == mode_q) begin
      deb_cnt_q <= '0;
    end else if (deb_cnt_q >= 16'(DEBOUNCE_CYC - 1)) begin
      deb_cnt_q <= '0;
      mode_q    <= mode_s; // R21
    end else begin
      deb_cnt_q <= deb_cnt_q + 16'h1;
    end
  end

  // first sample after reset release is taken straight from the synchroniser
  logic mode_ok;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) first_q <= 1'b1;
    else if (st_q == BSA_ST_POR) first_q <= 1'b0;
  end
  assign mode_ok = (st_q == BSA_ST_POR) ? mode_s : mode_q; // R21

  // unbuffered start flag and power-on snapshot
  logic unbuf_q;
  logic fault_q;
  logic [35:0] up_cnt_q;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      unbuf_q <= 1'b0;
    end else if (st_q == BSA_ST_POR) begin
      unbuf_q <= !backup_s || !batt_s || fault_q; // R04 R09 R10
    end
  end

  // battery fault flag: caught at start, cleared after a long charged run
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      fault_q  <= 1'b0;
      up_cnt_q <= '0;
    end else begin
      if (st_q == BSA_ST_POR && !batt_s) begin
        fault_q <= 1'b1; // R09
      end else if (fault_q && up_cnt_q >= 36'(BATT_OK_CYCLES - 1)) begin
        fault_q <= 1'b0; // R10
      end
      if (!batt_s || !fault_q) up_cnt_q <= '0;
      else                     up_cnt_q <= up_cnt_q + 36'h1; // R10
    end
  end
  // a power cycle is a reset; the fault must survive it, so the flag is
  // retained by the caller only through i_battery_ok staying low
  assign o_battery_fault_flag = fault_q;

  // start-up sequencer
  always_comb begin
    st_d = st_q;
    case (st_q)
      BSA_ST_POR:    st_d = (!backup_s || !batt_s) ? BSA_ST_CLEAR : BSA_ST_DECIDE; // R04 R09
      BSA_ST_CLEAR:  if (i_clear_done) st_d = (card_s || prot_s) ? BSA_ST_LOAD : BSA_ST_DECIDE;
      BSA_ST_LOAD:   if (i_load_done) st_d = BSA_ST_DECIDE;
      BSA_ST_DECIDE: begin
        if (unbuf_q) st_d = (mode_ok && hand_s) ? BSA_ST_RUN : BSA_ST_STOP; // R07
        else         st_d = mode_ok ? BSA_ST_RUN : BSA_ST_STOP; // R01
      end
      BSA_ST_STOP:   if (mode_ok && !(unbuf_q && !hand_s)) st_d = BSA_ST_RUN; // R02
      BSA_ST_RUN:    if (!mode_ok) st_d = BSA_ST_STOP;
      default:       st_d = BSA_ST_POR;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) st_q <= BSA_ST_POR;
    else         st_q <= st_d;
  end

  // load source selection
  logic [1:0] src_q;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      src_q <= BSA_SRC_NONE;
    end else if (st_q == BSA_ST_CLEAR && i_clear_done) begin
      if (card_s)      src_q <= BSA_SRC_CARD; // R05
      else if (prot_s) src_q <= BSA_SRC_PROT; // R06
      else             src_q <= BSA_SRC_NONE;
    end
  end

  // program presence: battery-backed program or loaded image
  logic prog_q;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      prog_q <= 1'b0;
    end else if (st_q == BSA_ST_POR) begin
      prog_q <= backup_s && batt_s && cfg_s; // R03 R02
    end else if (st_q == BSA_ST_CLEAR) begin
      prog_q <= 1'b0; // R04
    end else if (st_q == BSA_ST_LOAD && i_load_done) begin
      prog_q <= 1'b1; // R05 R06
    end
  end

  // event log pulse
  logic log_q;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) log_q <= 1'b0;
    else         log_q <= (st_q == BSA_ST_POR) && (!backup_s || !batt_s); // R08
  end

  // image refresh pulse at each completed cycle
  logic refr_q;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) refr_q <= 1'b0;
    else         refr_q <= (st_q == BSA_ST_RUN) && i_cycle_done; // R14
  end

  assign o_run            = (st_q == BSA_ST_RUN);
  assign o_program_loaded = prog_q && (st_q == BSA_ST_RUN || st_q == BSA_ST_STOP);
  assign o_clear_req      = (st_q == BSA_ST_CLEAR);
  assign o_load_req       = (st_q == BSA_ST_LOAD);
  assign o_load_src       = src_q;
  assign o_log_auto_reset = log_q;
  assign o_image_refresh  = refr_q;

  // slot address allocation
  bsa_alloc_if alloc ();
  bsa_addr_calc u_calc (.a(alloc));
  logic slot_lim;
  assign slot_lim = i_hw_cfg ? (i_slot < SLOT_W'(MAX_CFG_ROW)) : 1'b1; // R15
  assign alloc.slot_idx = i_slot;
  assign alloc.kind     = bsa_mod_e'(i_slot_kind);
  assign alloc.hw_cfg   = i_hw_cfg;
  assign alloc.cfg_addr = i_slot_cfg_addr;

  logic [12:0] addr_q;
  logic [4:0]  span_q;
  logic        ok_q;
  logic        acc_q;
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      addr_q <= '0;
      span_q <= '0;
      ok_q   <= 1'b0;
      acc_q  <= 1'b0;
    end else begin
      addr_q <= alloc.start_addr; // R17
      span_q <= alloc.span;
      ok_q   <= alloc.in_range && slot_lim; // R13 R15
      acc_q  <= i_acc_img ? (i_acc_addr <= 13'(IMG_MAX)) : (i_acc_addr <= ADDR_MAX); // R13 R16
    end
  end
  assign o_slot_addr = addr_q;
  assign o_slot_span = span_q;
  assign o_slot_ok   = ok_q;
  assign o_acc_ok    = acc_q;

  sequence unbuf_start_s;
    st_q == BSA_ST_POR && !backup_s;
  endsequence
  sequence go_clear_s;
    ##1 st_q == BSA_ST_CLEAR;
  endsequence

  unbuf_clear_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R04
    unbuf_start_s |-> go_clear_s) else $error("lost backup did not clear");
  fault_set_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R09
    st_q == BSA_ST_POR && !batt_s |=> fault_q) else $error("fault flag not set");
  fault_hold_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R10
    fault_q && !batt_s |=> fault_q) else $error("fault cleared on bad battery");
  unbuf_run_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R07
    st_q == BSA_ST_DECIDE && unbuf_q && !hand_s |=> st_q != BSA_ST_RUN) else $error("run without handler");
  mode_follow_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R01
    st_q == BSA_ST_DECIDE && !unbuf_q |=> (st_q == BSA_ST_RUN) == $past(mode_ok)) else $error("mode not followed");
  log_event_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R08
    unbuf_start_s |=> o_log_auto_reset) else $error("auto reset not logged");
  card_src_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R05
    st_q == BSA_ST_CLEAR && i_clear_done && card_s |=> o_load_src == BSA_SRC_CARD) else $error("card not used");
  dig_addr_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R19
    alloc.kind == BSA_MOD_DIGITAL && !i_hw_cfg |=> o_slot_addr == 13'($past(i_slot)) * 13'h4)
    else $error("digital address wrong");
  ana_addr_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R20
    alloc.kind == BSA_MOD_ANALOG && !i_hw_cfg |=> o_slot_addr == 13'($past(i_slot)) * 13'h10 + 13'h100)
    else $error("analog address wrong");
  refresh_a: assert property (@(posedge i_clk) disable iff (!i_rstn) // R14
    o_run && i_cycle_done |=> o_image_refresh) else $error("image not refreshed");
endmodule // bsa_boot_alloc

// *** src/bsa_pkg.sv ***
package bsa_pkg;
  localparam int unsigned CLK_MHZ          = 250;
  localparam int unsigned BATT_OK_SEC      = 30;
  localparam int unsigned DEBOUNCE_US      = 1;
  localparam longint unsigned BATT_OK_CYC  = longint'(BATT_OK_SEC) * CLK_MHZ * 1000000;
  localparam int unsigned DEBOUNCE_CYC     = DEBOUNCE_US * CLK_MHZ;
  localparam int unsigned SLOT_W           = 5;
  localparam int unsigned MAX_SLOTS        = 32;
  localparam int unsigned MAX_CFG_ROW      = 8;
  localparam int unsigned ADDR_W           = 13;
  localparam logic [12:0] ADDR_MAX         = 13'h1fff;
  localparam int unsigned IMG_W            = 8;
  localparam logic [7:0]  IMG_MAX          = 8'hff;
  localparam logic [12:0] DIG_BASE         = 13'h000;
  localparam logic [12:0] ANA_BASE         = 13'h100;
  localparam int unsigned DIG_SHIFT        = 2;
  localparam int unsigned ANA_SHIFT        = 4;
  localparam logic [4:0]  DIG_SPAN         = 5'h04;
  localparam logic [4:0]  ANA_SPAN         = 5'h10;

  typedef enum logic [1:0] {
    BSA_MOD_NONE    = 2'h0,
    BSA_MOD_DIGITAL = 2'h1,
    BSA_MOD_ANALOG  = 2'h2,
    BSA_MOD_FUNC    = 2'h3
  } bsa_mod_e;

  typedef enum logic [2:0] {
    BSA_ST_POR     = 3'h0,
    BSA_ST_CLEAR   = 3'h1,
    BSA_ST_LOAD    = 3'h2,
    BSA_ST_DECIDE  = 3'h3,
    BSA_ST_STOP    = 3'h4,
    BSA_ST_RUN     = 3'h5
  } bsa_state_e;

  typedef enum logic [1:0] {
    BSA_SRC_NONE = 2'h0,
    BSA_SRC_CARD = 2'h1,
    BSA_SRC_PROT = 2'h2
  } bsa_src_e;
endpackage

// *** src/bsa_alloc_if.sv ***
interface bsa_alloc_if;
  import bsa_pkg::*;
  logic [SLOT_W-1:0] slot_idx;
  bsa_mod_e          kind;
  logic              hw_cfg;
  logic [ADDR_W-1:0] cfg_addr;
  logic [ADDR_W-1:0] start_addr;
  logic [4:0]        span;
  logic              in_range;
  modport core (output slot_idx, output kind, output hw_cfg, output cfg_addr,
                input start_addr, input span, input in_range);
  modport calc (input slot_idx, input kind, input hw_cfg, input cfg_addr,
                output start_addr, output span, output in_range);
endinterface

// *** src/bsa_addr_calc.sv ***
module bsa_addr_calc
  import bsa_pkg::*;
(
  bsa_alloc_if.calc a
);
  logic [ADDR_W-1:0] auto_addr;

  always_comb begin
    a.span = DIG_SPAN;
    auto_addr = '0;
    case (a.kind)
      BSA_MOD_DIGITAL: begin
        a.span = DIG_SPAN; // R18
        auto_addr = DIG_BASE + (ADDR_W'(a.slot_idx) << DIG_SHIFT); // R11 R19
      end
      BSA_MOD_ANALOG, BSA_MOD_FUNC: begin
        a.span = ANA_SPAN; // R18
        auto_addr = ANA_BASE + (ADDR_W'(a.slot_idx) << ANA_SHIFT); // R12 R20
      end
      default: begin
        a.span = '0;
        auto_addr = '0;
      end
    endcase
  end

  // configured address overrides the slot formula
  assign a.start_addr = a.hw_cfg ? a.cfg_addr : auto_addr; // R17
  assign a.in_range   = (a.kind != BSA_MOD_NONE) &&
                        ({1'b0, a.start_addr} + 14'(a.span) - 14'h1 <= {1'b0, ADDR_MAX}); // R13
endmodule // bsa_addr_calc

// *** testbench/bsa_backplane_model.sv ***
// backplane modules and firmware answering the start-up handshakes
module bsa_backplane_model
  import bsa_pkg::*;
#(
  parameter int CLR_LAT  = 3,
  parameter int LOAD_LAT = 12
) (
  // clock
  input  wire logic        i_clk,
  // requests from the allocator
  input  wire logic        i_clear_req,
  input  wire logic        i_load_req,
  input  wire logic [4:0]  i_slot,
  // answers
  output logic             o_clear_done,
  output logic             o_load_done,
  output logic [1:0]       o_slot_kind,
  output logic [12:0]      o_slot_cfg_addr
);
  logic [7:0] clr_cnt_q;
  logic [7:0] ld_cnt_q;

  always_ff @(posedge i_clk) begin
    clr_cnt_q <= i_clear_req ? clr_cnt_q + 8'h01 : 8'h00;
    ld_cnt_q  <= i_load_req ? ld_cnt_q + 8'h01 : 8'h00;
  end
  // one pulse per request; the request drops before the count can wrap
  assign o_clear_done = i_clear_req && (clr_cnt_q == 8'(CLR_LAT));
  assign o_load_done  = i_load_req && (ld_cnt_q == 8'(LOAD_LAT));

  // even slots digital, odd analog, last slot a function module
  always_comb begin
    if (i_slot == 5'h1f) o_slot_kind = 2'(BSA_MOD_FUNC);
    else if (i_slot[0]) o_slot_kind = 2'(BSA_MOD_ANALOG);
    else o_slot_kind = 2'(BSA_MOD_DIGITAL);
  end
  assign o_slot_cfg_addr = 13'h1000 | {8'h00, i_slot};
endmodule // bsa_backplane_model

// *** testbench/test_boot_and_slot_address_allocator.sv ***
module test_boot_and_slot_address_allocator;
  import bsa_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic i_clk, i_rstn, i_mode_run, i_backup_valid, i_battery_ok, i_card_present;
  logic i_prot_blocks, i_handler_block, i_valid_config, i_clear_done, i_load_done;
  logic i_cycle_done, i_hw_cfg, i_acc_img;
  logic [4:0]  i_slot;
  logic [1:0]  i_slot_kind;
  logic [12:0] i_slot_cfg_addr, i_acc_addr, o_slot_addr;
  logic o_run, o_program_loaded, o_clear_req, o_load_req, o_battery_fault_flag;
  logic o_log_auto_reset, o_image_refresh, o_slot_ok, o_acc_ok;
  logic [1:0]  o_load_src;
  logic [4:0]  o_slot_span;
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  logic seen_clr, seen_log;

  bsa_boot_alloc #(.BATT_OK_CYCLES(20)) bsa_boot_alloc_inst (.*);
  bsa_backplane_model bsa_backplane_model_inst (
    .i_clk(i_clk), .i_clear_req(o_clear_req), .i_load_req(o_load_req), .i_slot(i_slot),
    .o_clear_done(i_clear_done), .o_load_done(i_load_done), .o_slot_kind(i_slot_kind),
    .o_slot_cfg_addr(i_slot_cfg_addr));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [12:0] exp, input logic [12:0] got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (o_clear_req === 1'b1) seen_clr <= 1'b1;
    if (o_log_auto_reset === 1'b1) seen_log <= 1'b1;
    if (cyc == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  // power cycle with the given pins, then let start-up and debounce settle
  task automatic boot(input logic [6:0] p);
    @(posedge i_clk);
    {i_mode_run, i_backup_valid, i_battery_ok, i_card_present} <= p[6:3];
    {i_prot_blocks, i_handler_block, i_valid_config} <= p[2:0];
    i_rstn <= 1'b0;
    seen_clr = 1'b0;
    seen_log = 1'b0;
    repeat (20) @(posedge i_clk);
    #1;
    chk("reset run", 13'h0, {12'h0, o_run});
    chk("reset addr", 13'h0, o_slot_addr);
    @(posedge i_clk);
    i_rstn <= 1'b1;
    repeat (400) @(posedge i_clk);
    #1;
  endtask

  typedef struct {logic [4:0] slot; logic hw; logic img; logic [12:0] acc;
                  logic [12:0] addr; logic [4:0] span; logic ok; logic aok; logic full;} row_s;
  row_s rows[8] = '{
    '{5'h00, 1'b0, 1'b0, 13'h1fff, 13'h000, 5'h04, 1'b1, 1'b1, 1'b1},
    '{5'h01, 1'b0, 1'b1, 13'h00ff, 13'h110, 5'h10, 1'b1, 1'b1, 1'b1},
    '{5'h06, 1'b0, 1'b1, 13'h0100, 13'h018, 5'h04, 1'b1, 1'b0, 1'b1},
    '{5'h1f, 1'b0, 1'b0, 13'h0000, 13'h2f0, 5'h10, 1'b1, 1'b1, 1'b1},
    '{5'h1e, 1'b0, 1'b0, 13'h0100, 13'h078, 5'h04, 1'b1, 1'b1, 1'b1},
    '{5'h07, 1'b1, 1'b1, 13'h0000, 13'h1007, 5'h10, 1'b1, 1'b1, 1'b1},
    '{5'h02, 1'b1, 1'b0, 13'h0000, 13'h1002, 5'h04, 1'b1, 1'b1, 1'b1},
    '{5'h08, 1'b1, 1'b0, 13'h0000, 13'h0000, 5'h00, 1'b0, 1'b1, 1'b0}};

  initial begin
    {i_rstn, i_mode_run, i_backup_valid, i_battery_ok, i_card_present} = '0;
    {i_prot_blocks, i_handler_block, i_valid_config, i_cycle_done, i_hw_cfg} = '0;
    {i_acc_img, i_slot, i_acc_addr} = '0;
    boot(7'b1110001);
    chk("run", 13'h1, {12'h0, o_run});
    chk("loaded", 13'h1, {12'h0, o_program_loaded});
    chk("no clear", 13'h0, {12'h0, seen_clr});
    foreach (rows[k]) begin
      @(posedge i_clk);
      i_slot <= rows[k].slot;
      i_hw_cfg <= rows[k].hw;
      i_acc_img <= rows[k].img;
      i_acc_addr <= rows[k].acc;
      @(posedge i_clk);
      #1;
      if (rows[k].full) chk("slot addr", rows[k].addr, o_slot_addr);
      if (rows[k].full) chk("slot span", {8'h00, rows[k].span}, {8'h00, o_slot_span});
      chk("slot ok", {12'h0, rows[k].ok}, {12'h0, o_slot_ok});
      chk("acc ok", {12'h0, rows[k].aok}, {12'h0, o_acc_ok});
    end
    @(posedge i_clk);
    i_cycle_done <= 1'b1;
    @(posedge i_clk);
    i_cycle_done <= 1'b0;
    #1;
    chk("refresh", 13'h1, {12'h0, o_image_refresh});
    @(posedge i_clk);
    #1;
    chk("refresh end", 13'h0, {12'h0, o_image_refresh});
    boot(7'b0110001);
    chk("stop", 13'h0, {12'h0, o_run});
    boot(7'b1011010);
    chk("clear", 13'h1, {12'h0, seen_clr});
    chk("log", 13'h1, {12'h0, seen_log});
    chk("src card", 13'h1, {11'h0, o_load_src});
    chk("run card", 13'h1, {12'h0, o_run});
    boot(7'b1010100);
    chk("src prot", 13'h2, {11'h0, o_load_src});
    chk("no handler", 13'h0, {12'h0, o_run});
    boot(7'b1100011);
    chk("batt clear", 13'h1, {12'h0, seen_clr});
    chk("flag", 13'h1, {12'h0, o_battery_fault_flag});
    @(posedge i_clk);
    i_battery_ok <= 1'b1;
    repeat (10) @(posedge i_clk);
    #1;
    chk("flag early", 13'h1, {12'h0, o_battery_fault_flag});
    repeat (30) @(posedge i_clk);
    #1;
    chk("flag clear", 13'h0, {12'h0, o_battery_fault_flag});
    boot(7'b0110000);
    chk("factory stop", 13'h0, {12'h0, o_run});
    @(posedge i_clk);
    i_mode_run <= 1'b1;
    repeat (400) @(posedge i_clk);
    #1;
    chk("factory run", 13'h1, {12'h0, o_run});
    chk("no program", 13'h0, {12'h0, o_program_loaded});
    stop_test();
  end
endmodule // test_boot_and_slot_address_allocator
